/* File: hdl/mmu_cfg.svh */
`ifndef MMU_CFG_SVH
`define MMU_CFG_SVH

// =====================================================================
// register placement
`define REG_PAGE 8'hfe
`define REG_CFG 4'h0
`define REG_MODE 4'h1
`define REG_ZP 4'h2
`define REG_SP 4'h3
`define REG_STAT 4'h4

// =====================================================================
// field positions
`define CFG_IO_BIT 0
`define CFG_ROM_LO 1
`define CFG_ROM_HI 2
`define CFG_RAM_BANK 3
`define MODE_FLD_LO 0
`define MODE_FLD_HI 1
`define MODE_CART_A 2
`define MODE_CART_B 3
`define MODE_FS_OUT 4
`define MODE_FS_VAL 5
`define MODE_COL_OUT 6
`define MODE_COL_VAL 7

// =====================================================================
// reset values
`define CFG_RST 8'h00
`define MODE_RST 8'h00
`define ZP_RST 8'h00
`define SP_RST 8'h01

// =====================================================================
// timing
`define CLK_PERIOD_NS 100
`define PRE_SYSTEM_CLOCK_HALF_NS 500
`define PRE_SYSTEM_CLOCK_HALF_CYC ((`PRE_SYSTEM_CLOCK_HALF_NS) / (`CLK_PERIOD_NS))

`endif

/* File: hdl/mmu_pkg.sv */
package mmu_pkg;

    // =================================================================
    // operating modes, held in the low two bits of the mode register
    typedef enum logic [1:0]
    {
        MODE_NATIVE = 2'h0,
        MODE_LEGACY = 2'h1,
        MODE_ALT = 2'h2,
        MODE_SPARE = 2'h3
    } sys_mode_t;

    // =================================================================
    // host bus cycle sequencer
    typedef enum logic [3:0]
    {
        HS_IDLE = 4'h1,
        HS_SETUP = 4'h2,
        HS_HIGH = 4'h4,
        HS_HOLD = 4'h8
    } host_state_t;

    typedef struct packed
    {
        logic phi_q;
        logic mux_q;
        logic [7:0] cfg_q;
        logic [7:0] mode_q;
        logic [7:0] zp_q;
        logic [7:0] sp_q;
        logic wr_pend_q;
        logic [3:0] wr_idx_q;
        logic cas_on_q;
        logic [7:0] ta_q;
        logic ta_oe_q;
        logic rom_lo_q;
        logic rom_hi_q;
        logic io_q;
        logic sysm_q;
        logic alt_n_q;
        logic [1:0] cas_n_q;
        logic [7:0] d_o_q;
        logic d_oe_q;
        logic [3:0] port_o_q;
        logic [3:0] port_oe_q;
    } dev_state_t;

    typedef struct packed
    {
        host_state_t st_q;
        logic [7:0] cnt_q;
        logic phi_q;
        logic mux_q;
        logic rw_q;
        logic [15:0] addr_q;
        logic [7:0] d_o_q;
        logic d_oe_q;
        logic aec_q;
        logic [3:0] pull_q;
        logic busy_q;
        logic done_q;
        logic [7:0] rdata_q;
        logic cs_sys_q;
        logic cs_func_q;
        logic cs_ext_q;
        logic cs_ram_q;
        logic cs_io_q;
    } host_state_reg_t;

endpackage

/* File: hdl/mmu_link_if.sv */
`timescale 1ns/1ps
interface mmu_link_if;

    // =================================================================
    // processor side bus
    logic [3:0] addr_lo;
    logic combined_addr_lo;
    logic combined_addr_hi;
    logic [7:0] addr_hi;
    logic [7:0] host_d_o;
    logic host_d_oe;
    logic [7:0] dev_d_o;
    logic dev_d_oe;
    logic [7:0] data;
    logic rw;
    logic pre_system_clock;
    logic row_col_select_strobe;
    logic bus_owner_level;

    // =================================================================
    // translated address and strobes
    logic [7:0] ta_o;
    logic ta_oe;
    logic [7:0] translated_addr_out;
    logic ram_bank0_strobe_n;
    logic ram_bank1_strobe_n;
    logic rom_bank_sel_lo;
    logic rom_bank_sel_hi;
    logic io_window_select;
    logic system_mode_out;
    logic alt_cpu_enable_n;

    // =================================================================
    // port lines: 0 cart_line_a_n, 1 cart_line_b_n, 2 column switch,
    // 3 fast_serial_direction; pulled up, far end may only pull low
    logic [3:0] port_o;
    logic [3:0] port_oe;
    logic [3:0] host_pull;
    logic [3:0] port_level;

    assign data = dev_d_oe ? dev_d_o : (host_d_oe ? host_d_o : 8'hff);
    assign translated_addr_out = ta_oe ? ta_o : 8'hff;
    assign port_level = (port_oe & port_o) | (~port_oe & ~host_pull);

    modport dev
    (
        input addr_lo, combined_addr_lo, combined_addr_hi, addr_hi, data, rw,
        input pre_system_clock, row_col_select_strobe, bus_owner_level,
        input port_level,
        output dev_d_o, dev_d_oe, ta_o, ta_oe, ram_bank0_strobe_n,
        output ram_bank1_strobe_n, rom_bank_sel_lo, rom_bank_sel_hi,
        output io_window_select, system_mode_out, alt_cpu_enable_n,
        output port_o, port_oe
    );

    modport host
    (
        output addr_lo, combined_addr_lo, combined_addr_hi, addr_hi, rw,
        output host_d_o, host_d_oe, pre_system_clock, row_col_select_strobe,
        output bus_owner_level, host_pull,
        input data, translated_addr_out, ram_bank0_strobe_n, ram_bank1_strobe_n,
        input rom_bank_sel_lo, rom_bank_sel_hi, io_window_select,
        input system_mode_out, alt_cpu_enable_n, port_level
    );

endinterface

/* File: hdl/mmu_host.sv */
`timescale 1ns/1ps
`include "mmu_cfg.svh"
module mmu_host
    import mmu_pkg::*;
#(
    parameter int HALF_CYC = `PRE_SYSTEM_CLOCK_HALF_CYC
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // request
    input wire logic REQ,
    input wire logic REQ_WRITE,
    input wire logic [15:0] REQ_ADDR,
    input wire logic [7:0] REQ_DATA,
    input wire logic AEC_LEVEL,
    input wire logic [3:0] PULL_LOW,
    // answer
    output logic BUSY,
    output logic DONE,
    output logic [7:0] RDATA,
    // decoded selects
    output logic CS_SYS_ROM,
    output logic CS_FUNC_ROM,
    output logic CS_EXT_ROM,
    output logic CS_RAM,
    output logic CS_IO,
    // link
    mmu_link_if.host LINK
);

    host_state_reg_t s;
    host_state_reg_t n;
    logic [3:0] page;
    logic in_rom;

    // =================================================================
    // bus cycle sequencer and address decode
    always_comb
    begin
        n = s;
        n.done_q = 1'b0;
        n.aec_q = AEC_LEVEL;
        n.pull_q = PULL_LOW; // RULE21
        page = s.addr_q[15:12];
        in_rom = (page >= 4'h4);
        unique case (s.st_q)
            HS_IDLE:
            begin
                if (REQ)
                begin
                    n.st_q = HS_SETUP;
                    n.addr_q = REQ_ADDR;
                    n.rw_q = ~REQ_WRITE; // RULE11
                    n.d_o_q = REQ_DATA;
                    n.busy_q = 1'b1;
                    n.cnt_q = 8'(HALF_CYC - 1);
                end
            end
            HS_SETUP:
            begin
                if (s.cnt_q == 8'h00)
                begin
                    n.st_q = HS_HIGH;
                    n.phi_q = 1'b1; // RULE12
                    n.d_oe_q = ~s.rw_q;
                    n.cnt_q = 8'(HALF_CYC - 1);
                end
                else
                    n.cnt_q = s.cnt_q - 8'h01;
            end
            HS_HIGH:
            begin
                n.mux_q = 1'b1;
                if (s.cnt_q == 8'h00)
                begin
                    n.st_q = HS_HOLD;
                    n.phi_q = 1'b0; // RULE12
                    n.mux_q = 1'b0;
                    n.rdata_q = LINK.data;
                    n.cnt_q = 8'(HALF_CYC - 1);
                end
                else
                    n.cnt_q = s.cnt_q - 8'h01;
            end
            HS_HOLD:
            begin
                // data and address held a half period past the fall
                if (s.cnt_q == 8'h00)
                begin
                    n.st_q = HS_IDLE;
                    n.d_oe_q = 1'b0;
                    n.rw_q = 1'b1;
                    n.busy_q = 1'b0;
                    n.done_q = 1'b1;
                end
                else
                    n.cnt_q = s.cnt_q - 8'h01;
            end
        endcase
        n.cs_sys_q = 1'b0;
        n.cs_func_q = 1'b0;
        n.cs_ext_q = 1'b0;
        n.cs_ram_q = 1'b0;
        n.cs_io_q = 1'b0;
        if (LINK.system_mode_out)
        begin
            if (LINK.io_window_select && page == 4'hd)
                n.cs_io_q = 1'b1; // RULE22
            else if (in_rom)
            begin
                n.cs_sys_q = ~LINK.rom_bank_sel_hi & ~LINK.rom_bank_sel_lo; // RULE22
                n.cs_func_q = LINK.rom_bank_sel_hi & ~LINK.rom_bank_sel_lo;
                n.cs_ext_q = ~LINK.rom_bank_sel_hi & LINK.rom_bank_sel_lo;
                n.cs_ram_q = LINK.rom_bank_sel_hi & LINK.rom_bank_sel_lo;
            end
            else
                n.cs_ram_q = 1'b1;
        end
        else
        begin
            // legacy: bank lines carry no meaning here
            n.cs_io_q = (page == 4'hd); // RULE2
            n.cs_ram_q = (page != 4'hd);
        end
    end

    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s <= '0;
            s.st_q <= HS_IDLE;
            s.rw_q <= 1'b1;
            s.aec_q <= 1'b1;
        end
        else
            s <= n;
    end

    // =================================================================
    // outputs
    assign BUSY = s.busy_q;
    assign DONE = s.done_q;
    assign RDATA = s.rdata_q;
    assign CS_SYS_ROM = s.cs_sys_q;
    assign CS_FUNC_ROM = s.cs_func_q;
    assign CS_EXT_ROM = s.cs_ext_q;
    assign CS_RAM = s.cs_ram_q;
    assign CS_IO = s.cs_io_q;
    assign LINK.addr_lo = s.addr_q[3:0];
    assign LINK.combined_addr_lo = s.addr_q[4] | s.addr_q[5];
    assign LINK.combined_addr_hi = s.addr_q[6] | s.addr_q[7];
    assign LINK.addr_hi = s.addr_q[15:8];
    assign LINK.rw = s.rw_q;
    assign LINK.host_d_o = s.d_o_q;
    assign LINK.host_d_oe = s.d_oe_q;
    assign LINK.pre_system_clock = s.phi_q;
    assign LINK.row_col_select_strobe = s.mux_q;
    assign LINK.bus_owner_level = s.aec_q;
    assign LINK.host_pull = s.pull_q;

endmodule

/* File: hdl/mmu_device.sv */
`timescale 1ns/1ps
`include "mmu_cfg.svh"
// Overview of operation
// RULE1: bank select pair encodes current ROM slot
// RULE2: legacy decoder ignores both bank select lines
// RULE3: native mode io select follows io bit
// RULE4: legacy mode holds io select high
// RULE5: system mode low legacy, high native
// RULE6: alternate enable low only in alternate mode
// RULE7: translated outputs float when bus not owned
// RULE8: no translation while bus not owned
// RULE9: owned bus gets translated high address
// RULE10: column strobes pick first or second bank
// RULE11: processor drives read high, write low
// RULE12: address at clock rise, data at fall
// RULE13: pre-system clock switches write strobes early
// RULE14: reset restores every internal register
// RULE15: registers load from data lines on writes
// RULE16: multiplex strobe clocks internal sections
// RULE17: cart line a senses legacy, drives native
// RULE18: cart line b senses legacy, drives native
// RULE19: column port senses switch, output reserved
// RULE20: fast serial port sets disk direction
// RULE21: far end only pulls port lines low
// RULE22: native decoder uses address and status lines
// RULE23: commit write at clock fall, owned cycles
module mmu_device
    import mmu_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // link
    mmu_link_if.dev LINK
);

    dev_state_t s;
    dev_state_t n;
    logic phi_rise;
    logic phi_fall;
    logic mux_rise;
    logic mux_fall;
    logic sel;
    logic [3:0] idx;
    logic [7:0] rd_val;
    logic [7:0] status;
    sys_mode_t mode;
    logic [3:0] port_drive;
    logic [3:0] port_val;

    // =================================================================
    // edge detection; inputs are already synchronous to CLK
    always_comb
    begin
        phi_rise = LINK.pre_system_clock & ~s.phi_q;
        phi_fall = ~LINK.pre_system_clock & s.phi_q;
        mux_rise = LINK.row_col_select_strobe & ~s.mux_q;
        mux_fall = ~LINK.row_col_select_strobe & s.mux_q;
        idx = LINK.addr_lo;
        sel = LINK.bus_owner_level && (LINK.addr_hi == `REG_PAGE)
            && !LINK.combined_addr_lo && !LINK.combined_addr_hi;
        mode = sys_mode_t'(s.mode_q[`MODE_FLD_HI:`MODE_FLD_LO]);
        status = {2'h0, s.mode_q[`MODE_FLD_HI:`MODE_FLD_LO], LINK.port_level};
        unique case (idx)
            `REG_CFG: rd_val = s.cfg_q;
            `REG_MODE: rd_val = s.mode_q;
            `REG_ZP: rd_val = s.zp_q;
            `REG_SP: rd_val = s.sp_q;
            `REG_STAT: rd_val = status; // RULE19
            default: rd_val = 8'h00;
        endcase
    end

    // =================================================================
    // port line drive: a line is released unless driven as an output
    always_comb
    begin
        port_drive[0] = (mode != MODE_LEGACY); // RULE17
        port_val[0] = s.mode_q[`MODE_CART_A];
        port_drive[1] = (mode != MODE_LEGACY); // RULE18
        port_val[1] = s.mode_q[`MODE_CART_B];
        // column output kept behind its own enable since it is spare
        port_drive[2] = s.mode_q[`MODE_COL_OUT]; // RULE19
        port_val[2] = s.mode_q[`MODE_COL_VAL];
        port_drive[3] = s.mode_q[`MODE_FS_OUT]; // RULE20
        port_val[3] = s.mode_q[`MODE_FS_VAL];
    end

    // =================================================================
    // next state
    always_comb
    begin
        n = s;
        n.phi_q = LINK.pre_system_clock;
        n.mux_q = LINK.row_col_select_strobe; // RULE16

        // address is valid at the rise, so the target is latched there
        if (phi_rise)
        begin
            n.wr_pend_q = sel && !LINK.rw; // RULE12
            n.wr_idx_q = idx;
            n.d_oe_q = sel && LINK.rw;
            n.d_o_q = rd_val;
        end
        if (phi_fall)
        begin
            n.d_oe_q = 1'b0;
            n.wr_pend_q = 1'b0;
            if (s.wr_pend_q && LINK.bus_owner_level) // RULE23
            begin
                unique case (s.wr_idx_q) // RULE15
                    `REG_CFG: n.cfg_q = LINK.data;
                    `REG_MODE: n.mode_q = LINK.data;
                    `REG_ZP: n.zp_q = LINK.data;
                    `REG_SP: n.sp_q = LINK.data;
                    default: n.cfg_q = s.cfg_q;
                endcase
            end
        end

        // writes open the strobe at the clock rise instead of waiting
        // for the multiplex strobe, giving the DRAM write more time
        if (mux_rise || (phi_rise && !LINK.rw)) // RULE13
            n.cas_on_q = 1'b1; // RULE16
        else if (mux_fall)
            n.cas_on_q = 1'b0;
        n.cas_n_q[0] = ~(n.cas_on_q & ~s.cfg_q[`CFG_RAM_BANK]); // RULE10
        n.cas_n_q[1] = ~(n.cas_on_q & s.cfg_q[`CFG_RAM_BANK]); // RULE10

        // translation only for processor cycles
        n.ta_oe_q = LINK.bus_owner_level; // RULE7
        if (!LINK.bus_owner_level)
            n.ta_q = LINK.addr_hi; // RULE8
        else if (LINK.addr_hi == 8'h00)
            n.ta_q = s.zp_q; // RULE9
        else if (LINK.addr_hi == 8'h01)
            n.ta_q = s.sp_q; // RULE9
        else
            n.ta_q = LINK.addr_hi; // RULE9

        n.rom_lo_q = s.cfg_q[`CFG_ROM_LO]; // RULE1
        n.rom_hi_q = s.cfg_q[`CFG_ROM_HI]; // RULE1
        n.io_q = (mode == MODE_LEGACY) ? 1'b1 : s.cfg_q[`CFG_IO_BIT]; // RULE3 RULE4
        n.sysm_q = (mode != MODE_LEGACY); // RULE5
        n.alt_n_q = (mode != MODE_ALT); // RULE6

        for (int i = 0; i < 4; i++)
        begin
            n.port_oe_q[i] = port_drive[i];
            n.port_o_q[i] = port_val[i];
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            s <= '0; // RULE14
            s.cfg_q <= `CFG_RST;
            s.mode_q <= `MODE_RST;
            s.zp_q <= `ZP_RST;
            s.sp_q <= `SP_RST;
            s.cas_n_q <= 2'h3;
            s.io_q <= 1'b0;
            s.sysm_q <= 1'b1;
            s.alt_n_q <= 1'b1;
            s.port_oe_q <= 4'h3;
        end
        else
            s <= n;
    end

    // =================================================================
    // outputs, all straight from flip-flops
    assign LINK.dev_d_o = s.d_o_q;
    assign LINK.dev_d_oe = s.d_oe_q;
    assign LINK.ta_o = s.ta_q;
    assign LINK.ta_oe = s.ta_oe_q;
    assign LINK.ram_bank0_strobe_n = s.cas_n_q[0];
    assign LINK.ram_bank1_strobe_n = s.cas_n_q[1];
    assign LINK.rom_bank_sel_lo = s.rom_lo_q;
    assign LINK.rom_bank_sel_hi = s.rom_hi_q;
    assign LINK.io_window_select = s.io_q;
    assign LINK.system_mode_out = s.sysm_q;
    assign LINK.alt_cpu_enable_n = s.alt_n_q;
    assign LINK.port_o = s.port_o_q;
    assign LINK.port_oe = s.port_oe_q;

endmodule

/* File: sim/mmu_monitor.sv */
`timescale 1ns/1ps
module mmu_monitor
(
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // processor side
    input wire logic [3:0] addr_lo,
    input wire logic combined_addr_lo,
    input wire logic combined_addr_hi,
    input wire logic [7:0] addr_hi,
    input wire logic rw,
    input wire logic row_col_select_strobe,
    input wire logic bus_owner_level,
    input wire logic dev_d_oe,
    // device outputs
    input wire logic [7:0] translated_addr_out,
    input wire logic ram_bank0_strobe_n,
    input wire logic ram_bank1_strobe_n,
    input wire logic io_window_select,
    input wire logic system_mode_out,
    input wire logic alt_cpu_enable_n,
    input wire logic [3:0] port_oe
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // =================================================================
    // assertions
    // one cycle of lag is allowed before the address lines float
    AST_FLOAT_UNOWNED: assert property (!bus_owner_level && $past(bus_owner_level) == 1'b0
        |-> translated_addr_out == 8'hff) else $error("address lines driven while not owned");
    AST_LEGACY_IO_HIGH: assert property (!system_mode_out [*3] |-> io_window_select)
        else $error("io select low in legacy mode");
    AST_ALT_NOT_LEGACY: assert property (!alt_cpu_enable_n [*3] |-> system_mode_out)
        else $error("alternate enable low outside alternate mode");
    AST_ONE_BANK: assert property (ram_bank0_strobe_n || ram_bank1_strobe_n)
        else $error("both column strobes low");
    AST_HIGH_PAGE_PASS: assert property (bus_owner_level && $past(bus_owner_level)
        && $past(ARST_N, 2) && $stable(addr_hi) && addr_hi > 8'h01
        |-> translated_addr_out == addr_hi) else $error("high page not passed through");
    AST_RESET_LEVELS: assert property ($rose(ARST_N) |-> system_mode_out && alt_cpu_enable_n
        && ram_bank0_strobe_n && ram_bank1_strobe_n && !io_window_select)
        else $error("outputs not at initial levels after reset");
    AST_LEGACY_CART_IN: assert property (!system_mode_out [*3] |-> port_oe[1:0] == 2'b00)
        else $error("cartridge lines driven in legacy mode");
    AST_DRIVE_ON_READ: assert property (dev_d_oe |-> rw)
        else $error("device drives data in a write cycle");
    AST_READ_ANSWER: assert property ($rose(row_col_select_strobe) && rw && bus_owner_level
        && addr_hi == 8'hfe && !combined_addr_lo && !combined_addr_hi && addr_lo < 4'h5
        |-> ##[0:3] dev_d_oe) else $error("register read not answered");

    // =================================================================
    // covers
    COV_LEGACY: cover property (!system_mode_out);
    COV_ALT: cover property (!alt_cpu_enable_n);
    COV_BANK1: cover property (!ram_bank1_strobe_n);
endmodule

/* File: sim/test_memory_banking_unit.sv */
`timescale 1ns/1ps
module test_memory_banking_unit;
    logic CLK;
    logic ARST_N;
    logic REQ;
    logic REQ_WRITE;
    logic [15:0] REQ_ADDR;
    logic [7:0] REQ_DATA;
    logic AEC_LEVEL;
    logic [3:0] PULL_LOW;
    logic BUSY;
    logic DONE;
    logic [7:0] RDATA;
    logic [4:0] cs;
    logic [7:0] ta_seen;
    logic seen0;
    logic seen1;
    logic early;
    logic [7:0] cs_exp [4] = '{8'h01, 8'h04, 8'h02, 8'h08};
    int failures;
    int tests_run;

    // =================================================================
    // design under test, both ends joined by the link
    mmu_link_if i_mmu_link_if();
    mmu_host #(.HALF_CYC(2)) i_mmu_host
    (
        .CLK(CLK), .ARST_N(ARST_N), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
        .REQ_DATA(REQ_DATA), .AEC_LEVEL(AEC_LEVEL), .PULL_LOW(PULL_LOW), .BUSY(BUSY),
        .DONE(DONE), .RDATA(RDATA), .CS_SYS_ROM(cs[0]), .CS_FUNC_ROM(cs[1]),
        .CS_EXT_ROM(cs[2]), .CS_RAM(cs[3]), .CS_IO(cs[4]), .LINK(i_mmu_link_if)
    );
    mmu_device i_mmu_device (.CLK(CLK), .ARST_N(ARST_N), .LINK(i_mmu_link_if));
    mmu_monitor i_mmu_monitor
    (
        .CLK(CLK), .ARST_N(ARST_N), .addr_lo(i_mmu_link_if.addr_lo),
        .combined_addr_lo(i_mmu_link_if.combined_addr_lo),
        .combined_addr_hi(i_mmu_link_if.combined_addr_hi), .addr_hi(i_mmu_link_if.addr_hi),
        .rw(i_mmu_link_if.rw), .row_col_select_strobe(i_mmu_link_if.row_col_select_strobe),
        .bus_owner_level(i_mmu_link_if.bus_owner_level), .dev_d_oe(i_mmu_link_if.dev_d_oe),
        .translated_addr_out(i_mmu_link_if.translated_addr_out),
        .ram_bank0_strobe_n(i_mmu_link_if.ram_bank0_strobe_n),
        .ram_bank1_strobe_n(i_mmu_link_if.ram_bank1_strobe_n),
        .io_window_select(i_mmu_link_if.io_window_select),
        .system_mode_out(i_mmu_link_if.system_mode_out),
        .alt_cpu_enable_n(i_mmu_link_if.alt_cpu_enable_n), .port_oe(i_mmu_link_if.port_oe)
    );

    // =================================================================
    // clock and watchdog
    initial
    begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        #500000;
        failures++;
        final_report();
    end

    // =================================================================
    // tasks
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask

    // one processor cycle; strobes and the translated page are watched mid-cycle
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        bit first;
        n = 0;
        first = 1'b1;
        early = 1'b0;
        seen0 = 1'b0;
        seen1 = 1'b0;
        ta_seen = 8'h00;
        @(posedge CLK);
        REQ <= 1'b1;
        REQ_WRITE <= wr;
        REQ_ADDR <= a;
        REQ_DATA <= d;
        @(posedge CLK);
        REQ <= 1'b0;
        do
        begin
            @(posedge CLK);
            #1;
            n++;
            if (n == 1)
                check({7'h00, BUSY}, 8'h01);
            // a write opens the strobe by the first multiplex-high cycle, a read not yet
            if (i_mmu_link_if.row_col_select_strobe === 1'b1 && first)
            begin
                first = 1'b0;
                early = (i_mmu_link_if.ram_bank0_strobe_n === 1'b0);
            end
            if (i_mmu_link_if.ram_bank0_strobe_n === 1'b0)
                seen0 = 1'b1;
            if (i_mmu_link_if.ram_bank1_strobe_n === 1'b0)
                seen1 = 1'b1;
            if (i_mmu_link_if.row_col_select_strobe === 1'b1)
                ta_seen = i_mmu_link_if.translated_addr_out;
        end
        while (DONE !== 1'b1 && n < 40);
        if (n >= 40)
        begin
            failures++;
            final_report();
        end
    endtask

    // mode outputs lag the commit, so let them settle
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        access(1'b1, a, d);
        repeat (3) @(posedge CLK);
        #1;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        access(1'b0, a, 8'h00);
        check(RDATA, exp);
    endtask

    // =================================================================
    // tests
    initial
    begin
        ARST_N = 1'b0;
        REQ = 1'b0;
        REQ_WRITE = 1'b0;
        REQ_ADDR = 16'h0000;
        REQ_DATA = 8'h00;
        AEC_LEVEL = 1'b1;
        PULL_LOW = 4'h0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rdc(16'hfe00, 8'h00);
        rdc(16'hfe01, 8'h00);
        rdc(16'hfe02, 8'h00);
        rdc(16'hfe03, 8'h01);
        check({7'h00, i_mmu_link_if.system_mode_out}, 8'h01);
        check({7'h00, i_mmu_link_if.alt_cpu_enable_n}, 8'h01);
        for (int v = 0; v < 4; v++)
        begin
            wr(16'hfe00, 8'(v << 1));
            rdc(16'hfe00, 8'(v << 1));
            check({6'h00, i_mmu_link_if.rom_bank_sel_hi, i_mmu_link_if.rom_bank_sel_lo}, 8'(v));
            check({3'h0, cs}, cs_exp[v]);
        end
        wr(16'hfe00, 8'h01);
        check({7'h00, i_mmu_link_if.io_window_select}, 8'h01);
        wr(16'hfe00, 8'h00);
        check({7'h00, i_mmu_link_if.io_window_select}, 8'h00);
        access(1'b0, 16'h2000, 8'h00);
        check({6'h00, seen1, seen0}, 8'h01);
        check({3'h0, cs}, 8'h08);
        check({7'h00, early}, 8'h00);
        access(1'b1, 16'h2000, 8'h00);
        check({7'h00, early}, 8'h01);
        wr(16'hfe00, 8'h08);
        access(1'b0, 16'h2000, 8'h00);
        check({6'h00, seen1, seen0}, 8'h02);
        wr(16'hfe02, 8'h37);
        wr(16'hfe03, 8'h5a);
        access(1'b0, 16'h0012, 8'h00);
        check(ta_seen, 8'h37);
        access(1'b0, 16'h0112, 8'h00);
        check(ta_seen, 8'h5a);
        access(1'b0, 16'h8012, 8'h00);
        check(ta_seen, 8'h80);
        @(posedge CLK);
        AEC_LEVEL <= 1'b0;
        access(1'b0, 16'h0012, 8'h00);
        check(ta_seen, 8'hff);
        wr(16'hfe00, 8'h0f);
        @(posedge CLK);
        AEC_LEVEL <= 1'b1;
        rdc(16'hfe00, 8'h08);
        // column switch pulled low, carts and fast serial driven high
        @(posedge CLK);
        PULL_LOW <= 4'h4;
        wr(16'hfe01, 8'h3c);
        access(1'b0, 16'hfe04, 8'h00);
        check({2'h0, RDATA[5:0]}, 8'h0b);
        wr(16'hfe01, 8'h1c);
        check({4'h0, i_mmu_link_if.port_level}, 8'h03);
        @(posedge CLK);
        PULL_LOW <= 4'h1;
        wr(16'hfe01, 8'h01);
        check({7'h00, i_mmu_link_if.system_mode_out}, 8'h00);
        check({7'h00, i_mmu_link_if.io_window_select}, 8'h01);
        access(1'b0, 16'hfe04, 8'h00);
        check({2'h0, RDATA[5:0]}, 8'h1e);
        check({3'h0, cs}, 8'h08);
        wr(16'hfe01, 8'h02);
        check({6'h00, i_mmu_link_if.system_mode_out, i_mmu_link_if.alt_cpu_enable_n}, 8'h02);
        wr(16'hfe01, 8'h00);
        check({6'h00, i_mmu_link_if.system_mode_out, i_mmu_link_if.alt_cpu_enable_n}, 8'h03);
        // second reset in mid-run
        @(posedge CLK);
        ARST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        ARST_N <= 1'b1;
        rdc(16'hfe02, 8'h00);
        rdc(16'hfe00, 8'h00);
        final_report();
    end
endmodule
